// ### hdl/sae_ssi_encoder.sv
// Behaviour
// [RULE1] 12 step bits plus 12 turn bits
// [RULE2] Position plus status byte form four bytes
// [RULE3] Binary or Gray output by setting
// [RULE4] Copy non-volatile set to working at power-up
// [RULE5] Port writes working set; save copies out
// [RULE6] Default command resets; load command recopies
// [RULE7] Defaults: scale one, offset zero, clockwise
// [RULE8] Master clocks; word loads into 32-bit register
// [RULE9] Latch position once at burst start
// [RULE10] Falling edges retrigger the monoflop timer
// [RULE11] Master keeps clock period below monoflop period
// [RULE12] First rising edge gives MSB, then lower
// [RULE13] 32-bit mode: seven status bits after LSB
// [RULE14] 25-bit mode: status bit seven, separator
// [RULE15] Single read takes 32 or 25 clocks
// [RULE16] Continued clocking repeats word: 64 or 51
// [RULE17] Clocks after second read give zeros
// [RULE18] Busy low for monoflop period, then high
// [RULE19] Master pauses monoflop period plus 1 us
// [RULE20] Each new burst reloads latest position
// [RULE21] 70 kHz to 1 MHz; refresh 150 us
// [RULE22] Config port 2400 baud, 8N1
// [RULE23] Telegram payload: number plus three bytes
// [RULE24] Payload byte 10h is sent doubled
// [RULE25] Answer ACK when good, NAK when faulty
// [RULE26] Monoflop counts system clocks after synchronised edge
`timescale 1ns/100ps
`default_nettype none
module sae_ssi_encoder import sae_pkg::*; #(
	parameter int BIT_CYC = BAUD_CYC
) (
	input wire logic clk,
	input wire logic rst_n,
	input wire logic ce,
	input wire logic ssi_clk,
	input wire logic [POS_W-1:0] raw_position,
	input wire logic [7:0] raw_status,
	input wire logic cfg_rxd,
	output logic ssi_data,
	output logic cfg_txd
);
	localparam int MONO_W = $clog2(MONO_CYC + 1);
	// ==========================================
	// Parameter store and configuration port
	sae_param_t work;
	sae_telegram_t tel_q, tel_d;
	logic rx_valid, tx_ready;
	logic [7:0] rx_byte;
	logic tx_valid_q, tx_valid_d;
	logic [7:0] tx_byte_q, tx_byte_d;
	sae_param_store u_store (
		.clk(clk),
		.rst_n(rst_n),
		.ce(ce),
		.tel(tel_q),
		.work(work)
	);
	sae_uart #(.BIT_CYC(BIT_CYC)) u_uart (
		.clk(clk),
		.rst_n(rst_n),
		.ce(ce),
		.rxd(cfg_rxd),
		.rx_valid(rx_valid),
		.rx_byte(rx_byte),
		.tx_valid(tx_valid_q),
		.tx_byte(tx_byte_q),
		.tx_ready(tx_ready),
		.txd(cfg_txd)
	); // [RULE22]
	// ==========================================
	// Telegram receiver
	sae_pstate_t pst_q, pst_d;
	logic [2:0] nb_q, nb_d;
	logic [31:0] buf_q, buf_d;
	logic [7:0] bcc_q, bcc_d, reply_q, reply_d;
	logic bad_q, bad_d, take_w;
	logic [7:0] take_b;
	always_comb begin
		pst_d = pst_q;
		nb_d = nb_q;
		buf_d = buf_q;
		bcc_d = bcc_q;
		bad_d = bad_q;
		reply_d = reply_q;
		tx_valid_d = 1'b0;
		tx_byte_d = tx_byte_q;
		tel_d = '{1'b0, buf_q[31:24], buf_q[23:0]};
		take_w = 1'b0;
		take_b = rx_byte;
		case (pst_q)
			P_IDLE: begin
				if (rx_valid && rx_byte == CH_STX) begin
					pst_d = P_ACK_STX;
					nb_d = 3'h0;
					bcc_d = 8'h00;
					bad_d = 1'b0;
				end
			end
			P_ACK_STX: begin
				if (tx_ready) begin
					tx_valid_d = 1'b1;
					tx_byte_d = CH_DLE;
					pst_d = P_DATA;
				end
			end
			P_DATA: begin
				if (rx_valid) begin
					bcc_d = bcc_q ^ rx_byte;
					if (rx_byte == CH_DLE) begin
						pst_d = P_ESC;
					end else begin
						take_w = 1'b1;
					end
				end
			end
			P_ESC: begin
				if (rx_valid) begin
					bcc_d = bcc_q ^ rx_byte;
					pst_d = P_DATA;
					if (rx_byte == CH_DLE) begin
						take_w = 1'b1; // [RULE24]
					end else if (rx_byte == CH_ETX) begin
						pst_d = P_BCC;
					end else begin
						bad_d = 1'b1;
					end
				end
			end
			P_BCC: begin
				if (rx_valid) begin
					pst_d = P_REPLY;
					if (rx_byte == bcc_q && !bad_q && nb_q == PAYLOAD_BYTES) begin
						reply_d = CH_ACK; // [RULE25]
						tel_d.valid = 1'b1; // [RULE23]
					end else begin
						reply_d = CH_NAK; // [RULE25]
					end
				end
			end
			P_REPLY: begin
				if (tx_ready) begin
					tx_valid_d = 1'b1;
					tx_byte_d = reply_q;
					pst_d = P_IDLE;
				end
			end
			default: pst_d = P_IDLE;
		endcase
		// Payload beyond four bytes spoils the telegram
		if (take_w) begin
			if (nb_q < PAYLOAD_BYTES) begin
				buf_d = {buf_q[23:0], take_b};
				nb_d = nb_q + 3'h1; // [RULE23]
			end else begin
				bad_d = 1'b1;
			end
		end
	end
	always_ff @(posedge clk) begin
		if (!rst_n) begin
			pst_q <= P_IDLE;
			nb_q <= 3'h0;
			buf_q <= 32'h00000000;
			bcc_q <= 8'h00;
			bad_q <= 1'b0;
			reply_q <= CH_NAK;
			tx_valid_q <= 1'b0;
			tx_byte_q <= 8'h00;
			tel_q <= '0;
		end else if (ce) begin
			pst_q <= pst_d;
			nb_q <= nb_d;
			buf_q <= buf_d;
			bcc_q <= bcc_d;
			bad_q <= bad_d;
			reply_q <= reply_d;
			tx_valid_q <= tx_valid_d;
			tx_byte_q <= tx_byte_d;
			tel_q <= tel_d;
		end
	end
	// ==========================================
	// Position processing, refreshed on a fixed tick
	logic [10:0] ref_q, ref_d;
	logic [POS_W-1:0] pos_q, pos_d, dir_w, bin_w;
	logic [2*POS_W-1:0] prod_w;
	// Raw input is {turns, steps}, both 12 bits wide
	always_comb begin
		dir_w = work.dir_ccw ? ~raw_position : raw_position; // [RULE1]
		prod_w = dir_w * work.scaling_factor;
		bin_w = prod_w[POS_W-1:0] + work.offset;
		pos_d = pos_q;
		ref_d = ref_q - 11'h001;
		if (ref_q == 11'h000) begin
			ref_d = 11'(REFRESH_CYC - 1); // [RULE21]
			pos_d = work.gray ? (bin_w ^ (bin_w >> 1)) : bin_w; // [RULE3]
		end
	end
	always_ff @(posedge clk) begin
		if (!rst_n) begin
			ref_q <= 11'h000;
			pos_q <= '0;
		end else if (ce) begin
			ref_q <= ref_d;
			pos_q <= pos_d;
		end
	end
	// ==========================================
	// Shift clock synchroniser and edge finder
	logic c1_q, c2_q, c3_q, clv_q, clv_d, fall_w, rise_w;
	always_comb begin
		clv_d = (c2_q == c3_q) ? c3_q : clv_q;
		fall_w = clv_q && !clv_d;
		rise_w = !clv_q && clv_d;
	end
	always_ff @(posedge clk) begin
		if (!rst_n) begin
			c1_q <= 1'b1;
			c2_q <= 1'b1;
			c3_q <= 1'b1;
			clv_q <= 1'b1;
		end else if (ce) begin
			c1_q <= ssi_clk;
			c2_q <= c1_q;
			c3_q <= c2_q;
			clv_q <= clv_d;
		end
	end
	// ==========================================
	// Monoflop, shift register and data line
	logic [MONO_W-1:0] mono_q, mono_d;
	logic [WORD_W-1:0] word_q, word_d, sr_q, sr_d, load_w;
	logic [6:0] cnt_q, cnt_d, period_w, limit_w;
	logic [6:0] gap_q, gap_d;
	logic busy_q, busy_d, data_q, data_d;
	always_comb begin
		// 25-bit form keeps bit 6 as the separator slot
		load_w = work.mode25 ? {pos_q, raw_status[7], 1'b0, 6'h00} // [RULE14]
			: {pos_q, raw_status[7:1], 1'b0}; // [RULE13] [RULE2]
		period_w = work.mode25 ? PERIOD25 : PERIOD32; // [RULE15]
		limit_w = work.mode25 ? LIMIT25 : LIMIT32;
		mono_d = mono_q;
		word_d = word_q;
		sr_d = sr_q;
		cnt_d = cnt_q;
		busy_d = busy_q;
		data_d = data_q;
		gap_d = gap_q;
		if (mono_q != '0) begin
			mono_d = mono_q - 1'b1;
		end
		if (fall_w) begin
			mono_d = MONO_W'(MONO_CYC); // [RULE10] [RULE26]
			busy_d = 1'b0;
			gap_d = 7'h00;
			if (mono_q == '0) begin
				word_d = load_w; // [RULE9] [RULE20]
				sr_d = load_w; // [RULE8]
				cnt_d = 7'h00;
			end
		end else if (rise_w && mono_q != '0) begin
			gap_d = 7'h00;
			if (cnt_q < limit_w) begin
				data_d = sr_q[WORD_W-1]; // [RULE12]
				sr_d = {sr_q[WORD_W-2:0], 1'b0};
				cnt_d = cnt_q + 7'h01;
				if (cnt_q + 7'h01 == period_w) begin
					sr_d = word_q; // [RULE16]
				end
			end else begin
				data_d = 1'b0; // [RULE17]
			end
		end else if (mono_q != '0 && clv_q && !busy_q) begin
			// Clock resting high longer than any legal half period ends the burst
			gap_d = gap_q + 7'h01;
			if (gap_q == 7'(GAP_CYC - 1)) begin
				busy_d = 1'b1;
				data_d = 1'b0; // [RULE18]
			end
		end
		if (mono_q == MONO_W'(1) && !fall_w) begin
			busy_d = 1'b0;
			data_d = 1'b1; // [RULE18]
		end
	end
	always_ff @(posedge clk) begin
		if (!rst_n) begin
			mono_q <= '0;
			word_q <= '0;
			sr_q <= '0;
			cnt_q <= 7'h00;
			gap_q <= 7'h00;
			busy_q <= 1'b0;
			data_q <= 1'b1;
		end else if (ce) begin
			mono_q <= mono_d;
			word_q <= word_d;
			sr_q <= sr_d;
			cnt_q <= cnt_d;
			gap_q <= gap_d;
			busy_q <= busy_d;
			data_q <= data_d;
		end
	end
	assign ssi_data = data_q;
endmodule
`default_nettype wire

// ### hdl/sae_pkg.sv
`default_nettype none
package sae_pkg;
	// ==========================================
	// Clock and timing
	localparam int CLK_HZ = 10000000;
	localparam int CLK_PERIOD_NS = 100;
	localparam int MONO_PERIOD_NS = 25000;
	localparam int MONO_CYC = (MONO_PERIOD_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
	// Longest half period of the slowest shift clock is about 7.1 us
	localparam int GAP_NS = 8000;
	localparam int GAP_CYC = (GAP_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
	localparam int REFRESH_NS = 150000;
	localparam int REFRESH_CYC = REFRESH_NS / CLK_PERIOD_NS;
	localparam int BAUD = 2400;
	localparam int BAUD_CYC = (CLK_HZ + BAUD / 2) / BAUD;
	// ==========================================
	// Word layout
	localparam int STEP_BITS = 12;
	localparam int TURN_BITS = 12;
	localparam int POS_W = STEP_BITS + TURN_BITS;
	localparam int WORD_W = 32;
	localparam logic [6:0] PERIOD32 = 7'h20;
	localparam logic [6:0] PERIOD25 = 7'h1a;
	localparam logic [6:0] LIMIT32 = 7'h40;
	localparam logic [6:0] LIMIT25 = 7'h33;
	localparam logic [2:0] PAYLOAD_BYTES = 3'h4;
	// ==========================================
	// Telegram characters and parameter numbers
	localparam logic [7:0] CH_STX = 8'h02;
	localparam logic [7:0] CH_ETX = 8'h03;
	localparam logic [7:0] CH_ACK = 8'h06;
	localparam logic [7:0] CH_DLE = 8'h10;
	localparam logic [7:0] CH_NAK = 8'h15;
	localparam logic [7:0] PN_OFFSET = 8'h04;
	localparam logic [7:0] PN_SCALE = 8'h08;
	localparam logic [7:0] PN_SAVE = 8'h1a;
	localparam logic [7:0] PN_LOAD = 8'h1b;
	localparam logic [7:0] PN_DEFAULT = 8'h1c;
	localparam logic [7:0] PN_MODE = 8'h1d;
	localparam logic [7:0] PN_GRAY = 8'h23;
	localparam logic [7:0] PN_DIR = 8'h26;
	// ==========================================
	// Carriers
	typedef struct packed {
		logic [23:0] scaling_factor;
		logic [23:0] offset;
		logic dir_ccw;
		logic gray;
		logic mode25;
	} sae_param_t;
	localparam sae_param_t PARAM_DEFAULT = '{24'h000001, 24'h000000, 1'b0, 1'b0, 1'b0};
	typedef struct packed {
		logic valid;
		logic [7:0] number;
		logic [23:0] data;
	} sae_telegram_t;
	typedef enum logic [2:0] {
		P_IDLE = 3'b000,
		P_ACK_STX = 3'b001,
		P_DATA = 3'b010,
		P_ESC = 3'b011,
		P_BCC = 3'b100,
		P_REPLY = 3'b101
	} sae_pstate_t;
endpackage
`default_nettype wire

// ### hdl/sae_uart.sv
`timescale 1ns/100ps
`default_nettype none
module sae_uart import sae_pkg::*; #(
	parameter int BIT_CYC = BAUD_CYC
) (
	input wire logic clk,
	input wire logic rst_n,
	input wire logic ce,
	input wire logic rxd,
	output logic rx_valid,
	output logic [7:0] rx_byte,
	input wire logic tx_valid,
	input wire logic [7:0] tx_byte,
	output logic tx_ready,
	output logic txd
);
	// ==========================================
	// Receiver
	logic s1_q, s2_q, s3_q, lvl_q, lvl_d;
	logic rbusy_q, rbusy_d, rv_q, rv_d;
	logic [15:0] rcnt_q, rcnt_d;
	logic [3:0] rbit_q, rbit_d;
	logic [7:0] rsh_q, rsh_d;
	// Level only moves once the two late stages agree
	always_comb begin
		lvl_d = (s2_q == s3_q) ? s3_q : lvl_q;
		rbusy_d = rbusy_q;
		rcnt_d = rcnt_q;
		rbit_d = rbit_q;
		rsh_d = rsh_q;
		rv_d = 1'b0;
		if (!rbusy_q) begin
			if (!lvl_q) begin
				rbusy_d = 1'b1;
				rcnt_d = 16'(BIT_CYC / 2);
				rbit_d = 4'h0;
			end
		end else if (rcnt_q != 16'h0000) begin
			rcnt_d = rcnt_q - 16'h0001;
		end else begin
			rcnt_d = 16'(BIT_CYC - 1);
			rbit_d = rbit_q + 4'h1;
			if (rbit_q == 4'h0) begin
				rbusy_d = !lvl_q; // Glitch on start bit aborts
			end else if (rbit_q == 4'h9) begin
				rbusy_d = 1'b0;
				rv_d = lvl_q; // Framing error drops the byte
			end else begin
				rsh_d = {lvl_q, rsh_q[7:1]};
			end
		end
	end
	always_ff @(posedge clk) begin
		if (!rst_n) begin
			s1_q <= 1'b1;
			s2_q <= 1'b1;
			s3_q <= 1'b1;
			lvl_q <= 1'b1;
			rbusy_q <= 1'b0;
			rcnt_q <= 16'h0000;
			rbit_q <= 4'h0;
			rsh_q <= 8'h00;
			rv_q <= 1'b0;
		end else if (ce) begin
			s1_q <= rxd;
			s2_q <= s1_q;
			s3_q <= s2_q;
			lvl_q <= lvl_d;
			rbusy_q <= rbusy_d;
			rcnt_q <= rcnt_d;
			rbit_q <= rbit_d;
			rsh_q <= rsh_d;
			rv_q <= rv_d;
		end
	end
	assign rx_valid = rv_q;
	assign rx_byte = rsh_q;
	// ==========================================
	// Transmitter, 8N1, LSB first
	logic tbusy_q, tbusy_d, txd_q, txd_d;
	logic [15:0] tcnt_q, tcnt_d;
	logic [3:0] tbit_q, tbit_d;
	logic [9:0] tsh_q, tsh_d;
	always_comb begin
		tbusy_d = tbusy_q;
		tcnt_d = tcnt_q;
		tbit_d = tbit_q;
		tsh_d = tsh_q;
		txd_d = txd_q;
		if (!tbusy_q) begin
			if (tx_valid) begin
				tbusy_d = 1'b1;
				tsh_d = {1'b1, tx_byte, 1'b0};
				tcnt_d = 16'(BIT_CYC - 1);
				tbit_d = 4'h0;
				txd_d = 1'b0;
			end
		end else if (tcnt_q != 16'h0000) begin
			tcnt_d = tcnt_q - 16'h0001;
		end else if (tbit_q == 4'h9) begin
			tbusy_d = 1'b0;
		end else begin
			tcnt_d = 16'(BIT_CYC - 1);
			tbit_d = tbit_q + 4'h1;
			tsh_d = {1'b1, tsh_q[9:1]};
			txd_d = tsh_q[1];
		end
	end
	always_ff @(posedge clk) begin
		if (!rst_n) begin
			tbusy_q <= 1'b0;
			tcnt_q <= 16'h0000;
			tbit_q <= 4'h0;
			tsh_q <= 10'h3ff;
			txd_q <= 1'b1;
		end else if (ce) begin
			tbusy_q <= tbusy_d;
			tcnt_q <= tcnt_d;
			tbit_q <= tbit_d;
			tsh_q <= tsh_d;
			txd_q <= txd_d;
		end
	end
	assign tx_ready = !tbusy_q;
	assign txd = txd_q;
endmodule
`default_nettype wire

// ### hdl/sae_param_store.sv
`timescale 1ns/100ps
`default_nettype none
module sae_param_store import sae_pkg::*; (
	input wire logic clk,
	input wire logic rst_n,
	input wire logic ce,
	input wire sae_telegram_t tel,
	output sae_param_t work
);
	// ==========================================
	// Working set and non-volatile copy
	sae_param_t work_q, work_d, nv_d;
	// Survives reset like an EEPROM; starts out holding the defaults
	sae_param_t nv_q = PARAM_DEFAULT;
	logic boot_q;
	always_comb begin
		work_d = work_q;
		nv_d = nv_q;
		if (boot_q) begin
			work_d = nv_q; // [RULE4]
		end else if (tel.valid) begin
			case (tel.number) // [RULE5]
				PN_OFFSET: work_d.offset = tel.data;
				PN_SCALE: work_d.scaling_factor = tel.data;
				PN_DIR: work_d.dir_ccw = tel.data[0];
				PN_GRAY: work_d.gray = tel.data[0]; // [RULE3]
				PN_MODE: work_d.mode25 = tel.data[0];
				PN_SAVE: nv_d = work_q; // [RULE5]
				PN_LOAD: work_d = nv_q; // [RULE6]
				PN_DEFAULT: work_d = PARAM_DEFAULT; // [RULE6] [RULE7]
				default: work_d = work_q;
			endcase
		end
	end
	always_ff @(posedge clk) begin
		if (!rst_n) begin
			work_q <= PARAM_DEFAULT;
			boot_q <= 1'b1;
		end else if (ce) begin
			work_q <= work_d;
			boot_q <= 1'b0;
		end
	end
	// Not reset on purpose: contents persist across resets
	always_ff @(posedge clk) begin
		if (ce) begin
			nv_q <= nv_d;
		end
	end
	assign work = work_q;
endmodule
`default_nettype wire

// ### test/sae_ssi_encoder_assertions.sv
`timescale 1ns/100ps
`default_nettype none
module sae_ssi_encoder_assertions import sae_pkg::*; #(
	parameter int BIT_CYC = BAUD_CYC
) (
	input wire logic clk,
	input wire logic rst_n,
	input wire logic ce,
	input wire logic ssi_clk,
	input wire logic [POS_W-1:0] raw_position,
	input wire logic [7:0] raw_status,
	input wire logic cfg_rxd,
	input wire logic ssi_data,
	input wire logic cfg_txd
);
	// ====
	// Helper counters
	logic pin_q, pin_d;
	logic [8:0] fall_q, fall_d, hi_q, hi_d;
	logic [15:0] lo_q, lo_d, rxi_q, rxi_d;
	// Saturating except lo_q, so a long idle never wraps into a fake burst
	always_comb begin
		pin_d = ssi_clk;
		fall_d = (pin_q && !ssi_clk) ? 9'h000 : fall_q + {8'h00, fall_q != 9'h1ff};
		hi_d = ssi_clk ? hi_q + {8'h00, hi_q != 9'h1ff} : 9'h000;
		lo_d = cfg_txd ? 16'h0000 : lo_q + 16'h0001;
		rxi_d = cfg_rxd ? rxi_q + {15'h0000, rxi_q != 16'hffff} : 16'h0000;
		if (!rst_n) {pin_d, fall_d, hi_d, lo_d, rxi_d} = {1'b1, 9'h1ff, 9'h1ff, 16'h0, 16'hffff};
	end
	// Registers only
	always_ff @(posedge clk) begin
		{pin_q, fall_q, hi_q, lo_q, rxi_q} <= {pin_d, fall_d, hi_d, lo_d, rxi_d};
	end
	// ====
	// Properties
	default clocking cb @(posedge clk); endclocking
	default disable iff (!rst_n);
	chk_reset_idle: assert property ($rose(rst_n) |-> ssi_data && cfg_txd)
		else $error("lines not idle after reset");
	chk_busy_low: assert property (fall_q inside {[9'd110:9'd240]} |-> !ssi_data)
		else $error("data not busy after burst");
	chk_ready_high: assert property (fall_q >= 9'd270 |-> ssi_data)
		else $error("data not ready with timer idle");
	chk_ready_time: assert property ($rose(ssi_data) && fall_q > 9'd100 |->
		fall_q inside {[9'd244:9'd262]}) else $error("ready at wrong time");
	chk_busy_entry: assert property ($fell(ssi_data) && fall_q > 9'd20 |->
		hi_q inside {[9'd78:9'd90]}) else $error("busy entry at wrong time");
	chk_bit_timing: assert property ($changed(ssi_data) && fall_q < 9'd20 |->
		hi_q inside {[9'd2:9'd8]}) else $error("data bit not after rising edge");
	chk_tx_bits: assert property ($rose(cfg_txd) |->
		lo_q % BIT_CYC == 0 && lo_q <= 9 * BIT_CYC) else $error("bad serial bit length");
	chk_tx_prompted: assert property ($fell(cfg_txd) |-> rxi_q <= 20 * BIT_CYC)
		else $error("reply without request");
	cover property ($rose(ssi_data) && fall_q > 9'd100);
	cover property ($fell(ssi_data) && fall_q > 9'd20);
	cover property ($fell(cfg_txd));
endmodule
bind sae_ssi_encoder sae_ssi_encoder_assertions #(.BIT_CYC(BIT_CYC)) sae_ssi_encoder_assertions_inst (
	.clk(clk), .rst_n(rst_n), .ce(ce), .ssi_clk(ssi_clk), .raw_position(raw_position),
	.raw_status(raw_status), .cfg_rxd(cfg_rxd), .ssi_data(ssi_data), .cfg_txd(cfg_txd));
`default_nettype wire

// ### test/sae_ctl_model.sv
`timescale 1ns/100ps
`default_nettype none
module sae_ctl_model import sae_pkg::*; #(
	parameter int BIT_NS = 1600
) (
	output logic ssi_clk,
	input wire logic ssi_data,
	output logic cfg_rxd,
	input wire logic cfg_txd
);
	logic got [0:69];
	// Both lines idle high
	initial begin
		ssi_clk = 1'b1;
		cfg_rxd = 1'b1;
	end
	// 800 ns clock; data taken late in the low phase, where it has settled
	task automatic burst(input int n);
		int i;
		#37;
		for (i = 0; i < n; i++) begin
			ssi_clk = 1'b0;
			#300;
			if (i > 0) got[i - 1] = ssi_data;
			#100;
			ssi_clk = 1'b1;
			#400;
		end
		#300;
		got[n - 1] = ssi_data;
		#30000;
	endtask
	// 8N1, LSB first
	task automatic tx(input logic [7:0] b);
		int i;
		cfg_rxd = 1'b0;
		#BIT_NS;
		for (i = 0; i < 8; i++) begin
			cfg_rxd = b[i];
			#BIT_NS;
		end
		cfg_rxd = 1'b1;
		#BIT_NS;
	endtask
	// Bounded wait for a start bit, then mid-bit sampling
	task automatic rx(output logic [7:0] b);
		int k;
		for (k = 0; k < 4000 && cfg_txd; k++) #100;
		#(BIT_NS * 3 / 2);
		for (k = 0; k < 8; k++) begin
			b[k] = cfg_txd;
			#BIT_NS;
		end
	endtask
	// Framed request; bad flips checksum bits
	task automatic tel(input logic [31:0] t, input logic [7:0] bad, output logic [7:0] dle,
		output logic [7:0] ans);
		logic [7:0] q [$];
		logic [7:0] x;
		int k;
		q = {};
		x = bad;
		for (k = 3; k >= 0; k--) begin
			q.push_back(t[8*k +: 8]);
			if (t[8*k +: 8] == CH_DLE) q.push_back(CH_DLE);
		end
		q.push_back(CH_DLE);
		q.push_back(CH_ETX);
		foreach (q[j]) x ^= q[j];
		fork
			tx(CH_STX);
			rx(dle);
		join
		foreach (q[j]) tx(q[j]);
		fork
			tx(x);
			rx(ans);
		join
		#(BIT_NS * 4);
	endtask
endmodule
`default_nettype wire

// ### test/tb.sv
`timescale 1ns/100ps
`default_nettype none
module tb import sae_pkg::*;;
	localparam int BITC = 16;
	logic clk, rst_n, ssi_clk, ssi_data, cfg_rxd, cfg_txd;
	logic [POS_W-1:0] raw_position;
	logic [7:0] raw_status;
	int errors, checks;
	// ====
	// Design and far side
	sae_ssi_encoder #(.BIT_CYC(BITC)) sae_ssi_encoder_inst (.clk(clk), .rst_n(rst_n), .ce(1'b1),
		.ssi_clk(ssi_clk), .raw_position(raw_position), .raw_status(raw_status),
		.cfg_rxd(cfg_rxd), .ssi_data(ssi_data), .cfg_txd(cfg_txd));
	sae_ctl_model #(.BIT_NS(BITC * 100)) sae_ctl_model_inst (.ssi_clk(ssi_clk),
		.ssi_data(ssi_data), .cfg_rxd(cfg_rxd), .cfg_txd(cfg_txd));
	initial clk = 1'b0;
	// 10 MHz
	always #50 clk = ~clk;
	// ====
	// Shared tasks
	task automatic chk(input logic [31:0] seen, input logic [31:0] exp, input string what);
		checks++;
		if (seen !== exp) begin
			errors++;
			$display("BAD %s expected %h seen %h", what, exp, seen);
		end
	endtask
	task automatic tally_and_finish;
		$display("checks %0d errors %0d", checks, errors);
		if (errors == 0 && checks > 0)
			$display("SIMULATION PASSED");
		else
			$display("SIMULATION FAILED");
		$finish;
	endtask
	// Word repeats every per bits up to lim clocks, zeros after that
	task automatic rd(input int n, input int per, input int lim, input logic [31:0] w);
		int i;
		sae_ctl_model_inst.burst(n);
		for (i = 0; i < n; i++)
			chk(sae_ctl_model_inst.got[i], (i < lim) ? w[31 - i % per] : 1'b0, "bit");
	endtask
	// ====
	// Scenarios
	task automatic t_read32;
		// Start late so that a refresh tick falls inside the burst
		#120000;
		fork
			rd(70, 32, 64, {raw_position, raw_status[7:1], 1'b0});
			begin
				#10000;
				@(negedge clk);
				raw_position = 24'h0f10e1;
			end
		join
		$display("done double read 32");
	endtask
	task automatic t_cfg;
		logic [7:0] d, a;
		sae_ctl_model_inst.tel({PN_MODE, 24'h000001}, 8'h00, d, a);
		chk(d, CH_DLE, "dle");
		chk(a, CH_ACK, "ack mode");
		sae_ctl_model_inst.tel({PN_OFFSET, 24'h000010}, 8'h00, d, a);
		chk(a, CH_ACK, "ack offset");
		sae_ctl_model_inst.tel({PN_GRAY, 24'h000001}, 8'h01, d, a);
		chk(a, CH_NAK, "nak");
		// Refresh tick must pass before the new set shows
		#200000;
		rd(55, 26, 51, {raw_position + 24'h000010, raw_status[7], 1'b0, 6'h00});
		$display("done config and read 25");
	endtask
	task automatic t_gray;
		logic [7:0] d, a;
		sae_ctl_model_inst.tel({PN_DEFAULT, 24'h000000}, 8'h00, d, a);
		chk(a, CH_ACK, "ack default");
		sae_ctl_model_inst.tel({PN_GRAY, 24'h000001}, 8'h00, d, a);
		chk(a, CH_ACK, "ack gray");
		#200000;
		rd(31, 32, 64, {raw_position ^ (raw_position >> 1), raw_status[7:1], 1'b0});
		$display("done defaults and gray");
	endtask
	// Saved set must come back through load and through a reset
	task automatic t_store;
		logic [7:0] d, a;
		logic [23:0] g;
		logic [31:0] w;
		g = ~raw_position;
		g = g * 24'h000003;
		w = {g ^ (g >> 1), raw_status[7:1], 1'b0};
		sae_ctl_model_inst.tel({PN_SCALE, 24'h000003}, 8'h00, d, a);
		chk(a, CH_ACK, "ack scale");
		sae_ctl_model_inst.tel({PN_DIR, 24'h000001}, 8'h00, d, a);
		chk(a, CH_ACK, "ack dir");
		sae_ctl_model_inst.tel({PN_SAVE, 24'h000000}, 8'h00, d, a);
		chk(a, CH_ACK, "ack save");
		// Working set only, so it must not reach the saved copy
		sae_ctl_model_inst.tel({PN_OFFSET, 24'h000005}, 8'h00, d, a);
		chk(a, CH_ACK, "ack offset 5");
		sae_ctl_model_inst.tel({PN_DEFAULT, 24'h000000}, 8'h00, d, a);
		chk(a, CH_ACK, "ack default 2");
		sae_ctl_model_inst.tel({PN_LOAD, 24'h000000}, 8'h00, d, a);
		chk(a, CH_ACK, "ack load");
		#200000;
		rd(32, 32, 64, w);
		// Second reset: the power-up copy must restore the saved set
		@(negedge clk);
		rst_n = 1'b0;
		repeat (12) @(negedge clk);
		rst_n = 1'b1;
		#200000;
		rd(32, 32, 64, w);
		$display("done save, load and power-up copy");
	endtask
	// ====
	// Main sequence
	initial begin
		errors = 0;
		checks = 0;
		rst_n = 1'b0;
		raw_position = 24'h5a3c96;
		raw_status = 8'h5a;
		repeat (12) @(negedge clk);
		rst_n = 1'b1;
		repeat (4) @(negedge clk);
		t_read32;
		t_cfg;
		t_gray;
		t_store;
		tally_and_finish;
	end
	// Run needs about 3.1 ms; roughly twice that means a hang
	initial begin
		#6000000;
		errors++;
		tally_and_finish;
	end
endmodule
`default_nettype wire
